// >>> rtl/lmx_defines.svh
// Constants for the LED matrix scan and PWM controller
// Contract
// - Writing 0xAE to the reset register restores every register default.
// - Power-up reset loads all register defaults, display starts blank.
// - Row switches enable one at a time, gap between rows.
// - Slot 33us active, 0.83us gap, columns lag row by 0.3us.
// - Each dot on-time has 256 steps, proportional to PWM/256.
// - PWM mode only; value n selects brightness step n.
// - Detect select 00 to 01/10 starts detection; results after 2 scans.
// - Result bits of dots switched off stay unchanged.
// - Detection runs once per trigger; host clears then sets again.
// - Pull resistors connect only while their row or column is off.
// - Both shutdowns keep every register intact.
// - Soft shutdown bit 0 blanks columns; registers stay accessible.
// - Shutdown pin low disables all drive; high releases it.
// - Register accesses still work during hardware shutdown.
// - Detect select 00/11 off, 01 open, 10 short.
// - Row count field sets scanned rows; default all 11 rows.
`ifndef LMX_DEFINES_SVH
`define LMX_DEFINES_SVH

// Register indices, byte address is four times the index
`define LMX_IDX_CFG 10'h000
`define LMX_IDX_GCC 10'h001
`define LMX_IDX_PULL 10'h002
`define LMX_IDX_OS 10'h003
`define LMX_IDX_TEMP 10'h024
`define LMX_IDX_SPREAD 10'h025
`define LMX_IDX_RST 10'h02F
`define LMX_IDX_STAT 10'h030
`define LMX_IDX_ONOFF 10'h040
`define LMX_IDX_PWM 10'h100

// Reset values and write masks
`define LMX_CFG_RST 8'h08
`define LMX_GCC_RST 8'h00
`define LMX_PULL_RST 8'h33
`define LMX_PULL_MASK 8'hF7
`define LMX_TEMP_MASK 8'h0F
`define LMX_SPREAD_MASK 8'hDF
`define LMX_RST_MAGIC 8'hAE

// Matrix geometry and field codes
`define LMX_COLS 18
`define LMX_OS_REGS 10'h021
`define LMX_DOTS 10'h0C6
`define LMX_DET_OFF 2'h0
`define LMX_DET_OPEN 2'h1
`define LMX_DET_SHORT 2'h2
`define LMX_DET_SCANS 2'h2
`define LMX_SWS_MAXSCAN 4'h9
`define LMX_SWS_NOSCAN 4'hA
`define LMX_ROW_LAST 4'hA
`define LMX_PWM_STEPS 256

// Timing
`define LMX_CLK_MHZ 200
`define LMX_SLOT_NS 33000
`define LMX_GAP_NS 830
`define LMX_CSDLY_NS 300

`endif

// >>> rtl/lmx_dot_mem.sv
// Dot PWM memory, one write port and two registered read ports
`timescale 1ns/100ps
module lmx_dot_mem (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_a_addr,
	output logic [7:0] rd_a_data,
	input wire logic [7:0] rd_b_addr,
	output logic [7:0] rd_b_data
);
	logic [7:0] mem [0:255];

	// Write port
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Bus read port
	always_ff @(posedge clock) begin
		rd_a_data <= mem[rd_a_addr];
	end

	// Scanner read port
	always_ff @(posedge clock) begin
		rd_b_data <= mem[rd_b_addr];
	end
endmodule

// >>> rtl/lmx_matrix_ctrl.sv
// LED matrix scan, PWM, detection and shutdown control with APB slave
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "lmx_defines.svh"
module lmx_matrix_ctrl import lmx_pkg::*; #(
	parameter int SLOT_CYCLES = `LMX_SLOT_NS * `LMX_CLK_MHZ / 1000
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shutdown_pin_n,
	input wire logic [17:0] col_fault_sense,
	output logic [10:0] row_switch,
	output logic [17:0] column_sink,
	output logic [10:0] row_pulldown_en,
	output logic [17:0] col_pullup_en,
	output logic [2:0] row_pull_code,
	output logic [2:0] col_pull_code,
	output logic [7:0] global_current_scale,
	output logic logic_level_sel,
	output logic detect_open,
	output logic detect_short
);
	localparam int GAP_CYC = (`LMX_GAP_NS * `LMX_CLK_MHZ + 999) / 1000;
	localparam int DLY_CYC = (`LMX_CSDLY_NS * `LMX_CLK_MHZ + 999) / 1000;
	localparam int STEP_RAW = SLOT_CYCLES / `LMX_PWM_STEPS;
	localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;
	localparam logic [15:0] GAP_END = 16'(GAP_CYC - 1);
	localparam logic [15:0] SLOT_END = 16'(SLOT_CYCLES - 1);
	localparam logic [15:0] STEP_END = 16'(STEP_CYC - 1);
	localparam logic [15:0] DLY_N = 16'(DLY_CYC);

	// True when index a lies in [base, base + n)
	function automatic logic in_win(input logic [9:0] a,
			input logic [9:0] base, input logic [9:0] n);
		return (a >= base) && (a < 10'(base + n));
	endfunction

	// Last row index from the row count field
	function automatic logic [3:0] last_row(input logic [3:0] scan_row_count);
		if (scan_row_count <= `LMX_SWS_MAXSCAN) begin
			return 4'(`LMX_ROW_LAST - scan_row_count);
		end else if (scan_row_count == `LMX_SWS_NOSCAN) begin
			return 4'h0;
		end
		return `LMX_ROW_LAST;
	endfunction

	logic [1:0] sdb_sync_ff;
	logic [17:0] flt_s1_ff;
	logic [17:0] flt_s2_ff;
	lmx_cfg_t cfg_ff;
	logic [7:0] gcc_ff;
	lmx_pull_t pull_ff;
	logic [7:0] temp_ff;
	logic [7:0] spread_ff;
	logic [5:0] on_ff [0:32];
	logic [5:0] os_ff [0:32];
	logic srst_ff;
	logic clr_ff;
	logic [7:0] clr_addr_ff;
	lmx_scan_t sc_ff;
	logic [15:0] cnt_ff;
	logic [15:0] stp_ff;
	logic [3:0] row_ff;
	logic [8:0] phase_ff;
	logic scan_done_ff;
	logic [7:0] colv_ff [0:17];
	lmx_det_t det_ff;
	logic [1:0] det_prev_ff;
	logic [1:0] det_mode_ff;
	logic [1:0] det_scans_ff;
	logic [10:0] row_sw_ff;
	logic [17:0] col_ff;
	logic [10:0] row_pd_ff;
	logic [17:0] col_pu_ff;
	logic det_open_ff;
	logic det_short_ff;
	logic [9:0] idx;
	logic acc;
	logic wr;
	logic reg_rst;
	logic hw_sd;
	logic trig;
	logic cap;
	logic noscan;
	logic slot_end;
	logic col_act;
	logic [5:0] on_base;
	logic [17:0] row_bits;
	logic [17:0] col_dim;
	logic [7:0] rd_data;
	logic unmapped;
	logic mem_we;
	logic [7:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rd_a;
	logic [7:0] mem_rd_b;
	logic [7:0] mem_b_addr;
	logic [10:0] nxt_row_sw;
	logic [17:0] nxt_col;

	// Pin synchronisers
	always_ff @(posedge clock) begin
		if (reset) begin
			sdb_sync_ff <= 2'h0;
			flt_s1_ff <= 18'h00000;
			flt_s2_ff <= 18'h00000;
		end else begin
			sdb_sync_ff <= {sdb_sync_ff[0], shutdown_pin_n};
			flt_s1_ff <= col_fault_sense;
			flt_s2_ff <= flt_s1_ff;
		end
	end
	assign hw_sd = ~sdb_sync_ff[1];

	// Bus decode; no gating by shutdown state
	assign idx = paddr[11:2];
	assign acc = psel & penable;
	assign pready = ~(clr_ff | srst_ff); // Stall during a soft reset and the PWM memory clear that follows any reset
	assign wr = acc & pwrite & pready;
	assign reg_rst = reset | srst_ff;

	// Magic value write to the reset register
	always_ff @(posedge clock) begin
		if (reset) begin
			srst_ff <= 1'b0;
		end else begin
			srst_ff <= wr && (idx == `LMX_IDX_RST) &&
				(pwdata[7:0] == `LMX_RST_MAGIC);
		end
	end

	// PWM memory clear after any reset
	always_ff @(posedge clock) begin
		if (reg_rst) begin
			clr_ff <= 1'b1;
			clr_addr_ff <= 8'h00;
		end else if (clr_ff) begin
			clr_addr_ff <= clr_addr_ff + 8'h01;
			clr_ff <= (clr_addr_ff != 8'hFF);
		end
	end

	// Configuration registers
	always_ff @(posedge clock) begin
		if (reg_rst) begin
			cfg_ff <= `LMX_CFG_RST;
			gcc_ff <= `LMX_GCC_RST;
			pull_ff <= `LMX_PULL_RST;
			temp_ff <= 8'h00;
			spread_ff <= 8'h00;
		end else if (wr) begin
			if (idx == `LMX_IDX_CFG) begin
				cfg_ff <= pwdata[7:0];
			end
			if (idx == `LMX_IDX_GCC) begin
				gcc_ff <= pwdata[7:0];
			end
			if (idx == `LMX_IDX_PULL) begin
				pull_ff <= pwdata[7:0] & `LMX_PULL_MASK;
			end
			if (idx == `LMX_IDX_TEMP) begin
				temp_ff <= pwdata[7:0] & `LMX_TEMP_MASK;
			end
			if (idx == `LMX_IDX_SPREAD) begin
				spread_ff <= pwdata[7:0] & `LMX_SPREAD_MASK;
			end
		end
	end

	// Dot on/off and open/short result registers
	for (genvar i = 0; i < 33; i++) begin : g_dot
		always_ff @(posedge clock) begin
			if (reg_rst) begin
				on_ff[i] <= 6'h00;
			end else if (wr && idx == 10'(`LMX_IDX_ONOFF + i)) begin
				on_ff[i] <= pwdata[5:0];
			end
		end
		// Only enabled dots take the sensed bit
		always_ff @(posedge clock) begin
			if (reg_rst) begin
				os_ff[i] <= 6'h00;
			end else if (cap && row_ff == 4'(i / 3)) begin
				os_ff[i] <= (os_ff[i] & ~on_ff[i]) |
					(flt_s2_ff[(i % 3) * 6 +: 6] & on_ff[i]);
			end
		end
	end

	// Read data mux
	always_comb begin
		rd_data = 8'h00;
		unmapped = 1'b0;
		if (idx == `LMX_IDX_CFG) begin
			rd_data = cfg_ff;
		end else if (idx == `LMX_IDX_GCC) begin
			rd_data = gcc_ff;
		end else if (idx == `LMX_IDX_PULL) begin
			rd_data = pull_ff;
		end else if (in_win(idx, `LMX_IDX_OS, `LMX_OS_REGS)) begin
			rd_data = {2'h0, os_ff[6'(idx - `LMX_IDX_OS)]};
		end else if (idx == `LMX_IDX_TEMP) begin
			rd_data = temp_ff;
		end else if (idx == `LMX_IDX_SPREAD) begin
			rd_data = spread_ff;
		end else if (idx == `LMX_IDX_RST) begin
			rd_data = 8'h00;
		end else if (idx == `LMX_IDX_STAT) begin
			rd_data = {row_ff, 2'h0, hw_sd, det_ff == DET_RUN};
		end else if (in_win(idx, `LMX_IDX_ONOFF, `LMX_OS_REGS)) begin
			rd_data = {2'h0, on_ff[6'(idx - `LMX_IDX_ONOFF)]};
		end else if (in_win(idx, `LMX_IDX_PWM, `LMX_DOTS)) begin
			rd_data = mem_rd_a;
		end else begin
			unmapped = 1'b1;
		end
	end
	assign prdata = {24'h000000, rd_data};
	assign pslverr = acc & unmapped;

	// Memory write port: clearing wins over the bus
	assign mem_we = clr_ff | (wr & in_win(idx, `LMX_IDX_PWM, `LMX_DOTS));
	assign mem_waddr = clr_ff ? clr_addr_ff : idx[7:0];
	assign mem_wdata = clr_ff ? 8'h00 : pwdata[7:0];
	assign mem_b_addr = 8'(row_ff) * 8'd18 + {3'h0, cnt_ff[4:0]};

	lmx_dot_mem u_mem (
		.clock(clock),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_a_addr(idx[7:0]),
		.rd_a_data(mem_rd_a),
		.rd_b_addr(mem_b_addr),
		.rd_b_data(mem_rd_b)
	);

	assign noscan = (cfg_ff.row_count == `LMX_SWS_NOSCAN);
	assign slot_end = (sc_ff == SCAN_ACTIVE) && (cnt_ff == SLOT_END);

	// Row slot sequencer, parked in the gap during hardware shutdown
	always_ff @(posedge clock) begin
		if (reset || hw_sd) begin
			sc_ff <= SCAN_GAP;
			cnt_ff <= 16'h0000;
			stp_ff <= 16'h0000;
			row_ff <= 4'h0;
			phase_ff <= 9'h000;
			scan_done_ff <= 1'b0;
		end else begin
			scan_done_ff <= 1'b0;
			unique case (sc_ff)
				SCAN_GAP: begin
					cnt_ff <= cnt_ff + 16'h0001;
					if (cnt_ff == GAP_END) begin
						sc_ff <= SCAN_ACTIVE;
						cnt_ff <= 16'h0000;
						stp_ff <= 16'h0000;
						phase_ff <= 9'h000;
					end
				end
				SCAN_ACTIVE: begin
					cnt_ff <= cnt_ff + 16'h0001;
					// PWM phase starts after the column delay
					if (cnt_ff >= DLY_N) begin
						stp_ff <= stp_ff + 16'h0001;
						if (stp_ff == STEP_END) begin
							stp_ff <= 16'h0000;
							if (!phase_ff[8]) begin
								phase_ff <= phase_ff + 9'h001;
							end
						end
					end
					if (slot_end) begin
						sc_ff <= SCAN_GAP;
						cnt_ff <= 16'h0000;
						if (row_ff >= last_row(cfg_ff.row_count)) begin
							row_ff <= 4'h0;
							scan_done_ff <= 1'b1;
						end else begin
							row_ff <= row_ff + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// Column PWM values fetched during the gap
	for (genvar c = 0; c < `LMX_COLS; c++) begin : g_col
		always_ff @(posedge clock) begin
			if (reset) begin
				colv_ff[c] <= 8'h00;
			end else if (sc_ff == SCAN_GAP && cnt_ff == 16'(c + 1)) begin
				colv_ff[c] <= mem_rd_b;
			end
		end
		assign col_dim[c] = phase_ff[7:0] < colv_ff[c];
	end

	// On bits of the current row
	assign on_base = {1'b0, row_ff, 1'b0} + {2'h0, row_ff};
	assign row_bits = {on_ff[on_base + 6'h02], on_ff[on_base + 6'h01],
		on_ff[on_base]};

	// Detection trigger and sequencing
	assign trig = (det_prev_ff == `LMX_DET_OFF) &&
		((cfg_ff.detect_select == `LMX_DET_OPEN) ||
		(cfg_ff.detect_select == `LMX_DET_SHORT));
	assign cap = (det_ff == DET_RUN) && slot_end &&
		(det_scans_ff == `LMX_DET_SCANS - 2'h1);
	always_ff @(posedge clock) begin
		if (reg_rst) begin
			det_ff <= DET_IDLE;
			det_prev_ff <= `LMX_DET_OFF;
			det_mode_ff <= `LMX_DET_OFF;
			det_scans_ff <= 2'h0;
		end else begin
			det_prev_ff <= cfg_ff.detect_select;
			if (trig) begin
				det_ff <= DET_RUN;
				det_mode_ff <= cfg_ff.detect_select;
				det_scans_ff <= 2'h0;
			end else begin
				unique case (det_ff)
					DET_IDLE: begin
						det_scans_ff <= 2'h0;
					end
					DET_RUN: begin
						if (scan_done_ff) begin
							det_scans_ff <= det_scans_ff + 2'h1;
							if (det_scans_ff == `LMX_DET_SCANS - 2'h1) begin
								det_ff <= DET_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// Next pin drive
	assign col_act = (sc_ff == SCAN_ACTIVE) && (cnt_ff >= DLY_N) &&
		!phase_ff[8];
	always_comb begin
		nxt_row_sw = 11'h000;
		nxt_col = 18'h00000;
		if (!hw_sd && sc_ff == SCAN_ACTIVE && !noscan) begin
			nxt_row_sw = 11'h001 << row_ff;
		end
		if (!hw_sd && cfg_ff.soft_shutdown_n && col_act) begin
			nxt_col = col_dim & row_bits;
		end
	end

	// Registered pin drive and pull enables
	always_ff @(posedge clock) begin
		if (reset) begin
			row_sw_ff <= 11'h000;
			col_ff <= 18'h00000;
			row_pd_ff <= 11'h000;
			col_pu_ff <= 18'h00000;
		end else begin
			row_sw_ff <= nxt_row_sw;
			col_ff <= nxt_col;
			row_pd_ff <= (!hw_sd && pull_ff.row_pd != 3'h0) ?
				~nxt_row_sw : 11'h000;
			col_pu_ff <= (!hw_sd && pull_ff.col_pu != 3'h0) ?
				~nxt_col : 18'h00000;
		end
	end

	// Detection mode outputs
	always_ff @(posedge clock) begin
		if (reset) begin
			det_open_ff <= 1'b0;
			det_short_ff <= 1'b0;
		end else begin
			det_open_ff <= det_ff == DET_RUN &&
				det_mode_ff == `LMX_DET_OPEN;
			det_short_ff <= det_ff == DET_RUN &&
				det_mode_ff == `LMX_DET_SHORT;
		end
	end

	assign row_switch = row_sw_ff;
	assign column_sink = col_ff;
	assign row_pulldown_en = row_pd_ff;
	assign col_pullup_en = col_pu_ff;
	assign row_pull_code = pull_ff.row_pd;
	assign col_pull_code = pull_ff.col_pu;
	assign global_current_scale = gcc_ff;
	assign logic_level_sel = cfg_ff.logic_level;
	assign detect_open = det_open_ff;
	assign detect_short = det_short_ff;
endmodule

// >>> rtl/lmx_pkg.sv
// Types shared by the LED matrix controller
package lmx_pkg;
	typedef struct packed {
		logic [3:0] row_count;
		logic logic_level;
		logic [1:0] detect_select;
		logic soft_shutdown_n;
	} lmx_cfg_t;
	typedef struct packed {
		logic phase_sel;
		logic [2:0] row_pd;
		logic rsvd;
		logic [2:0] col_pu;
	} lmx_pull_t;
	typedef enum {SCAN_GAP, SCAN_ACTIVE} lmx_scan_t;
	typedef enum {DET_IDLE, DET_RUN} lmx_det_t;
endpackage

// >>> verification/lmx_matrix_ctrl_tb_top.sv
// Self-checking bench for the LED matrix controller
`timescale 1ns/100ps
`include "lmx_defines.svh"
module lmx_matrix_ctrl_tb_top import lmx_pkg::*;;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic shutdown_pin_n = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd_v;
	logic pready, pslverr, detect_open, detect_short, logic_level_sel;
	logic [2:0] row_pull_code, col_pull_code;
	logic [10:0] row_switch;
	logic [17:0] column_sink, col_fault_sense;
	logic [32:0] exp_q[$];
	logic [32:0] e_v;
	logic [7:0] rnd, gcc_v;
	logic [7:0] lvl [4] = '{8'h00, 8'h40, 8'h80, 8'hFF};
	logic [7:0] gam [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	int on_n [4];
	int off_n;
	always #2.5 clock = ~clock;
	lmx_matrix_ctrl #(.SLOT_CYCLES(600)) dut_u (.clock(clock),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shutdown_pin_n(shutdown_pin_n),
		.col_fault_sense(col_fault_sense), .row_switch(row_switch),
		.column_sink(column_sink), .row_pulldown_en(),
		.col_pullup_en(), .row_pull_code(row_pull_code),
		.col_pull_code(col_pull_code), .global_current_scale(),
		.logic_level_sel(logic_level_sel), .detect_open(detect_open),
		.detect_short(detect_short));
	lmx_matrix_model model_u (.clock(clock), .row_switch(row_switch),
		.col_fault_sense(col_fault_sense));
	task automatic tally_and_finish();
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [7:0] d, input logic [32:0] ex);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		if (!w) exp_q.push_back(ex);
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd_v = prdata;
		if (idx == 10'h3FF) chk("pslverr", 32'h1, 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h0);
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b0, idx, 8'h00, {9'h100, 16'h0, d});
	endtask
	task automatic wait_row(input int r, input int lim);
		int n = 0;
		while (row_switch !== 11'(1 << r) && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk("row", 32'(1 << r), 32'(row_switch));
	endtask
	// Counts column 0 sink cycles over one row 0 slot
	task automatic measure(input logic [7:0] v, output int n);
		n = 0;
		wait_row(1, 9000);
		wr(`LMX_IDX_PWM, v);
		wait_row(0, 2000);
		while (row_switch[0] === 1'b1) begin
			@(posedge clock);
			n += int'(column_sink[0] === 1'b1);
		end
	endtask
	// Read results compared against the oldest note, plus timeout
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			fails++;
			tally_and_finish();
		end else if (psel && penable && pready && !pwrite &&
			exp_q.size() > 0) begin
			e_v = exp_q.pop_front();
			if (e_v[32]) chk("prdata", e_v[31:0], prdata);
		end
	end
	initial begin
		void'($urandom(32'h62f292ee));
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rd(`LMX_IDX_CFG, 8'h08);
		rd(`LMX_IDX_PULL, 8'h33);
		rd(`LMX_IDX_OS, 8'h00);
		rd(`LMX_IDX_RST, 8'h00);
		rd(10'h3FF, 8'h00);
		chk("pulls", 32'h1B, 32'({row_pull_code, col_pull_code}));
		chk("level", 32'h1, 32'(logic_level_sel));
		foreach (gam[i]) begin
			wr(`LMX_IDX_PWM + 10'(i), gam[i]);
			rd(`LMX_IDX_PWM + 10'(i), gam[i]);
		end
		gcc_v = 8'($urandom_range(255, 1));
		rnd = 8'($urandom_range(255, 0));
		if (rnd == `LMX_RST_MAGIC) rnd = 8'h00;
		wr(`LMX_IDX_GCC, gcc_v);
		wr(`LMX_IDX_RST, rnd);
		rd(`LMX_IDX_GCC, gcc_v);
		wr(`LMX_IDX_RST, `LMX_RST_MAGIC);
		rd(`LMX_IDX_GCC, 8'h00);
		rd(`LMX_IDX_PWM + 10'h002, 8'h00);
		// Two rows scanned, dot row 0 column 0 lit
		wr(`LMX_IDX_ONOFF, 8'h3F);
		wr(`LMX_IDX_ONOFF + 10'h003, 8'h01);
		wr(`LMX_IDX_CFG, 8'h99);
		wait_row(0, 9000);
		wait_row(1, 1000);
		wait_row(0, 1000);
		foreach (lvl[i]) measure(lvl[i], on_n[i]);
		chk("dark", 32'h0, 32'(on_n[0]));
		chk("steps", 32'h1, 32'(on_n[1] > 0 && on_n[2] > on_n[1] &&
			on_n[3] > on_n[2]));
		chk("half", 32'(on_n[1] * 2), 32'(on_n[2]));
		chk("full", 32'(on_n[1] * 255), 32'(on_n[3] * 64));
		wr(`LMX_IDX_CFG, 8'h98);
		measure(8'hFF, off_n);
		chk("soft_off", 32'h0, 32'(off_n));
		rd(`LMX_IDX_CFG, 8'h98);
		wr(`LMX_IDX_CFG, 8'h99);
		shutdown_pin_n <= 1'b0;
		repeat (8) @(posedge clock);
		chk("hw_rows", 32'h0, 32'(row_switch));
		chk("hw_cols", 32'h0, 32'(column_sink));
		wr(`LMX_IDX_GCC, 8'h0F);
		rd(`LMX_IDX_GCC, 8'h0F);
		rd(`LMX_IDX_CFG, 8'h99);
		shutdown_pin_n <= 1'b1;
		wait_row(0, 9000);
		wr(`LMX_IDX_PULL, 8'h00);
		// Codes 11, 10, 01 from cleared, row 1 off for the last
		for (int k = 3; k >= 1; k--) begin
			if (k == 1) wr(`LMX_IDX_ONOFF + 10'h003, 8'h00);
			wr(`LMX_IDX_CFG, 8'h99);
			wr(`LMX_IDX_CFG, 8'h99 | 8'(k << 1));
			apb(1'b0, `LMX_IDX_STAT, 8'h00, 33'h0);
			chk("busy", 32'(k != 3), 32'(rd_v[0]));
			chk("open", 32'(k == 1), 32'(detect_open));
			chk("short", 32'(k == 2), 32'(detect_short));
			for (int n = 0; n < 80 && rd_v[0] !== 1'b0; n++) begin
				repeat (100) @(posedge clock);
				apb(1'b0, `LMX_IDX_STAT, 8'h00, 33'h0);
			end
			chk("idle", 32'h0, 32'(rd_v[0]));
		end
		rd(`LMX_IDX_OS, 8'h08);
		rd(`LMX_IDX_OS + 10'h003, 8'h01);
		wr(`LMX_IDX_CFG, 8'h9B);
		apb(1'b0, `LMX_IDX_STAT, 8'h00, 33'h0);
		chk("rerun", 32'h0, 32'(rd_v[0]));
		tally_and_finish();
	end
endmodule

// >>> verification/lmx_matrix_model.sv
// LED matrix with fixed faulty dots, drives the fault sense lines
`timescale 1ns/100ps
module lmx_matrix_model #(
	parameter logic [17:0] FAULT_R0 = 18'h00008,
	parameter logic [17:0] FAULT_R1 = 18'h00001
) (
	input wire logic clock,
	input wire logic [10:0] row_switch,
	output logic [17:0] col_fault_sense
);
	logic [17:0] idle_ff = 18'h2AAAA;
	// Undriven sense lines wobble every cycle
	always_ff @(posedge clock) begin
		idle_ff <= ~idle_ff;
	end
	// Faults answer only while their row is driven
	always_comb begin
		col_fault_sense = idle_ff;
		if (row_switch[0]) col_fault_sense = FAULT_R0;
		if (row_switch[1]) col_fault_sense = FAULT_R1;
	end
endmodule

// >>> verification/lmx_monitor.sv
// Port checker for the LED matrix controller
`timescale 1ns/100ps
`include "lmx_defines.svh"
module lmx_monitor (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic shutdown_pin_n,
	input wire logic [10:0] row_switch,
	input wire logic [17:0] column_sink,
	input wire logic [10:0] row_pulldown_en,
	input wire logic [17:0] col_pullup_en,
	input wire logic [7:0] global_current_scale,
	input wire logic detect_open,
	input wire logic detect_short
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	row_onehot_a:
	assert property ($onehot0(row_switch)) else $error("two rows on");
	row_gap_a:
	assert property (|row_switch && $past(|row_switch) |-> $stable(row_switch))
		else $error("row changed with no gap");
	col_delay_a:
	assert property ($rose(|row_switch) |-> (column_sink == 18'h0)[*8])
		else $error("columns sink with the row");
	hw_off_a:
	assert property (!shutdown_pin_n [*5] |-> row_switch == 11'h0 &&
		column_sink == 18'h0 && row_pulldown_en == 11'h0 &&
		col_pullup_en == 18'h0) else $error("drive during shutdown");
	pull_off_a:
	assert property ((row_pulldown_en & row_switch) == 11'h0 &&
		(col_pullup_en & column_sink) == 18'h0) else $error("pull while on");
	det_excl_a:
	assert property (!(detect_open && detect_short)) else $error("both modes");
	rst_read_a:
	assert property (psel && penable && !pwrite &&
		paddr[11:2] == `LMX_IDX_RST |-> prdata == 32'h0)
		else $error("reset register readable");
	gcc_hold_a:
	assert property ($changed(global_current_scale) |->
		$past(psel && penable && pready && pwrite) ||
		$past(psel && penable && pready && pwrite, 2))
		else $error("scale changed without write");
endmodule

bind lmx_matrix_ctrl lmx_monitor mon_u (.clock(clock), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .shutdown_pin_n(shutdown_pin_n),
	.row_switch(row_switch), .column_sink(column_sink),
	.row_pulldown_en(row_pulldown_en), .col_pullup_en(col_pullup_en),
	.global_current_scale(global_current_scale),
	.detect_open(detect_open), .detect_short(detect_short));
